// ==== bench/fpp_flash_model.sv ====
// fpp_flash_model: behavioural flash array behind the write controller
// assumes single-cycle write and erase pulses from fpp_core on core_clk
`timescale 1ns/1ps
`default_nettype none
module fpp_flash_model (
  input  wire logic        core_clk,
  input  wire logic        flash_wr_en,
  input  wire logic [14:0] flash_wr_addr,
  input  wire logic [13:0] flash_wr_data,
  input  wire logic        flash_bulk_erase
);
  int          wr_count;
  int          erase_count;
  logic [14:0] last_addr;
  logic [13:0] last_data;

  // counting is enough: the bench asks only how many writes and erases landed, and the last address and data
  initial
  begin
    wr_count = 0;
    erase_count = 0;
    last_addr = 15'h7fff;
    last_data = 14'h3fff;
  end

  // a pulse is taken on the rising edge where it stands
  always @(posedge core_clk)
  begin
    if (flash_bulk_erase === 1'b1)
    begin
      erase_count++;
    end
    if (flash_wr_en === 1'b1)
    begin
      wr_count++;
      last_addr = flash_wr_addr;
      last_data = flash_wr_data;
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_flash_partition_protection.sv ====
// test_flash_partition_protection: directed bench for fpp_core
// assumes inputs driven on falling edges and a behavioural flash array
`timescale 1ns/1ps
`default_nettype none
module test_flash_partition_protection;
  import fpp_pkg::*;
  localparam logic [11:0] PC = 12'h0a5;  // arbitrary value
  localparam logic [13:0] PART_ID = {2'h3, PC};
  localparam logic [13:0] REV_ID = {2'h2, 6'h01, 6'h00};
  localparam logic [14:0] BOOT_END [8] = '{15'h1fff, 15'h1fff, 15'h1fff, 15'h1fff,
                                           15'h0fff, 15'h07ff, 15'h03ff, 15'h01ff};
  logic        core_clk, resetn, nv_wr_req, nv_rd_req, bulk_erase_req;
  logic [15:0] nv_addr;
  logic [13:0] nv_wdata, nv_rdata, flash_wr_data, r;
  logic        lv_prog_active, hv_present, master_clear_pin_enable, master_clear_pin;
  logic        fetch_valid, nv_rvalid, flash_wr_en, flash_bulk_erase, write_error_flag;
  logic        program_allowed, master_clear_n, code_protect_active, exec_violation;
  logic        boot_enabled, storage_enabled, h;
  logic [14:0] fetch_addr, flash_wr_addr, boot_end_addr;
  int          errors, total_checks, n0;

  fpp_core #(.PART_CODE(PC), .MAJOR_REV(6'h01), .MINOR_REV(6'h00)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .nv_wr_req(nv_wr_req), .nv_rd_req(nv_rd_req),
    .bulk_erase_req(bulk_erase_req), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
    .lv_prog_active(lv_prog_active), .hv_present(hv_present),
    .master_clear_pin_enable(master_clear_pin_enable), .master_clear_pin(master_clear_pin),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .nv_rdata(nv_rdata),
    .nv_rvalid(nv_rvalid), .flash_wr_en(flash_wr_en), .flash_wr_addr(flash_wr_addr),
    .flash_wr_data(flash_wr_data), .flash_bulk_erase(flash_bulk_erase),
    .write_error_flag(write_error_flag), .program_allowed(program_allowed),
    .master_clear_n(master_clear_n), .code_protect_active(code_protect_active),
    .exec_violation(exec_violation), .boot_end_addr(boot_end_addr),
    .boot_enabled(boot_enabled), .storage_enabled(storage_enabled));

  fpp_flash_model fm (.core_clk(core_clk), .flash_wr_en(flash_wr_en),
    .flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data),
    .flash_bulk_erase(flash_bulk_erase));

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one-cycle request, then settle time for the decoded outputs
  task automatic wr(input logic [15:0] a, input logic [13:0] d);
    @(negedge core_clk);
    nv_addr = a;
    nv_wdata = d;
    nv_wr_req = 1'b1;
    @(negedge core_clk);
    nv_wr_req = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  // read data is valid two edges after the request; wait is bounded
  task automatic rd(input logic [15:0] a, output logic [13:0] d);
    int n;
    @(negedge core_clk);
    nv_addr = a;
    nv_rd_req = 1'b1;
    @(negedge core_clk);
    nv_rd_req = 1'b0;
    n = 0;
    while (nv_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 4)
      chk(16'h0001, 16'h0000);
    d = nv_rdata;
  endtask

  task automatic erase();
    @(negedge core_clk);
    bulk_erase_req = 1'b1;
    @(negedge core_clk);
    bulk_erase_req = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask

  // the violation is a one-cycle pulse, so every cycle of the window is looked at
  task automatic fetch(input logic [14:0] a, output logic hit);
    @(negedge core_clk);
    fetch_addr = a;
    fetch_valid = 1'b1;
    @(negedge core_clk);
    fetch_valid = 1'b0;
    hit = (exec_violation === 1'b1);
    repeat (2)
    begin
      @(negedge core_clk);
      hit = hit | (exec_violation === 1'b1);
    end
  endtask

  // watchdog: the tests need a few hundred cycles, well under the 4000 cycles allowed
  initial
  begin
    #20us;
    errors++;
    wrap_up();
  end

  initial
  begin
    core_clk = 1'b0;
    resetn = 1'b0;
    nv_wr_req = 1'b0;
    nv_rd_req = 1'b0;
    bulk_erase_req = 1'b0;
    nv_addr = 16'h0000;
    nv_wdata = 14'h0000;
    lv_prog_active = 1'b0;
    hv_present = 1'b1;
    master_clear_pin_enable = 1'b1;
    master_clear_pin = 1'b1;
    fetch_valid = 1'b0;
    fetch_addr = 15'h0000;
    errors = 0;
    total_checks = 0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    rd(PART_PROT_ADDR, r);
    chk(r, PART_PROT_RESET);
    rd(CODE_PROT_ADDR, r);
    chk(r, CODE_PROT_RESET);
    rd(SETUP3_ADDR, r);
    chk(r, 14'h0000);
    chk(boot_enabled, 1'b0);
    chk(storage_enabled, 1'b0);
    wr(PART_WORD_ADDR, 14'h0000);
    wr(REV_WORD_ADDR, 14'h0000);
    rd(PART_WORD_ADDR, r);
    chk(r, PART_ID);
    rd(REV_WORD_ADDR, r);
    chk(r, REV_ID);
    chk(write_error_flag, 1'b0);
    $display("test reset_and_identity done");
    for (int s = 0; s < 8; s++)
    begin
      erase();
      wr(PART_PROT_ADDR, 14'h2b90 | 14'(s));
      chk(boot_enabled, 1'b1);
      chk(boot_end_addr, BOOT_END[s]);
    end
    wr(PART_PROT_ADDR, 14'h2b90);
    chk(boot_end_addr, 15'h01ff);
    $display("test boot_size done");
    erase();
    wr(PART_PROT_ADDR, 14'h2b87);
    chk(storage_enabled, 1'b1);
    fetch(15'h3f80, h);
    chk(h, 1'b1);
    fetch(15'h3f7f, h);
    chk(h, 1'b0);
    n0 = fm.wr_count;
    wr(16'h3f90, 14'h0123);
    chk(16'(fm.wr_count), 16'(n0 + 1));
    chk(fm.last_addr, 15'h3f90);
    chk(fm.last_data, 14'h0123);
    wr(PART_PROT_ADDR, 14'h2287);
    wr(16'h3f90, 14'h0456);
    wr(16'h0100, 14'h0456);
    chk(16'(fm.wr_count), 16'(n0 + 1));
    chk(write_error_flag, 1'b1);
    wr(16'h0300, 14'h0789);
    chk(16'(fm.wr_count), 16'(n0 + 2));
    wr(PART_PROT_ADDR, 14'h2207);
    wr(16'h0300, 14'h0789);
    chk(16'(fm.wr_count), 16'(n0 + 2));
    wr(PART_PROT_ADDR, 14'h3fff);
    rd(PART_PROT_ADDR, r);
    chk(r, 14'h2207);
    wr(PART_PROT_ADDR, 14'h2007);
    wr(PART_PROT_ADDR, 14'h0007);
    rd(PART_PROT_ADDR, r);
    chk(r, 14'h2007);
    erase();
    rd(PART_PROT_ADDR, r);
    chk(r, PART_PROT_RESET);
    chk(write_error_flag, 1'b0);
    $display("test protection done");
    wr(CODE_PROT_ADDR, 14'h0000);
    chk(code_protect_active, 1'b1);
    wr(CODE_PROT_ADDR, 14'h0001);
    chk(code_protect_active, 1'b1);
    n0 = fm.erase_count;
    erase();
    chk(16'(fm.erase_count), 16'(n0 + 1));
    chk(code_protect_active, 1'b0);
    rd(CODE_PROT_ADDR, r);
    chk(r, CODE_PROT_RESET);
    $display("test code_protect done");
    master_clear_pin_enable = 1'b0;
    master_clear_pin = 1'b0;
    lv_prog_active = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(master_clear_n, 1'b0);
    wr(PART_PROT_ADDR, 14'h0b9f);
    rd(PART_PROT_ADDR, r);
    chk(r, PART_PROT_RESET);
    lv_prog_active = 1'b0;
    repeat (4) @(negedge core_clk);
    wr(PART_PROT_ADDR, 14'h0b9f);
    rd(PART_PROT_ADDR, r);
    chk(r, 14'h0b9f);
    chk(master_clear_n, 1'b1);
    hv_present = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(program_allowed, 1'b0);
    n0 = fm.wr_count;
    wr(16'h0200, 14'h0055);
    chk(16'(fm.wr_count), 16'(n0));
    hv_present = 1'b1;
    repeat (4) @(negedge core_clk);
    erase();
    chk(program_allowed, 1'b1);
    $display("test programming_pin done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== core/fpp_cfg_mem.sv ====
// fpp_cfg_mem: small storage for the two writable setup words
// assumes single port use from the protection core on the same clock
`timescale 1ns/1ps
`default_nettype none
module fpp_cfg_mem (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        wr_en,
  input  wire logic        wr_sel,
  input  wire logic [13:0] wr_data,
  input  wire logic        rd_sel,
  output logic      [13:0] rd_data
);
  import fpp_pkg::*;
  logic [13:0] word_q [2];
  // erased state after reset stands in for unprogrammed cells
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      word_q[0] <= PART_PROT_RESET;
      word_q[1] <= CODE_PROT_RESET;
      rd_data   <= PART_PROT_RESET;
    end
    else
    begin
      if (wr_en)
        word_q[wr_sel] <= wr_data;
      rd_data <= word_q[rd_sel];
    end
  end
endmodule
`default_nettype wire

// ==== core/fpp_core.sv ====
// fpp_core: partition, write-protect and code-protect decode for user flash
// assumes a programmer/self-write port on core_clk and a flash write controller downstream
`timescale 1ns/1ps
`default_nettype none
module fpp_core #(
  parameter logic [11:0] PART_CODE = 12'h0a5,  // arbitrary value
  parameter logic [5:0]  MAJOR_REV = 6'h01,    // arbitrary value
  parameter logic [5:0]  MINOR_REV = 6'h00     // arbitrary value
) (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  nv_wr_req,
  input  wire logic                  nv_rd_req,
  input  wire logic                  bulk_erase_req,
  input  wire logic [fpp_pkg::ADDR_W-1:0] nv_addr,
  input  wire logic [fpp_pkg::WORD_W-1:0] nv_wdata,
  input  wire logic                  lv_prog_active,
  input  wire logic                  hv_present,
  input  wire logic                  master_clear_pin_enable,
  input  wire logic                  master_clear_pin,
  input  wire logic                  fetch_valid,
  input  wire logic [14:0]           fetch_addr,
  output logic      [fpp_pkg::WORD_W-1:0] nv_rdata,
  output logic                       nv_rvalid,
  output logic                       flash_wr_en,
  output logic      [14:0]           flash_wr_addr,
  output logic      [13:0]           flash_wr_data,
  output logic                       flash_bulk_erase,
  output logic                       write_error_flag,
  output logic                       program_allowed,
  output logic                       master_clear_n,
  output logic                       code_protect_active,
  output logic                       exec_violation,
  output logic      [14:0]           boot_end_addr,
  output logic                       boot_enabled,
  output logic                       storage_enabled
);
  import fpp_pkg::*;

  typedef struct packed {
    fpp_state_e  st;
    logic [1:0]  mc_sync;
    logic [1:0]  lvp_sync;
    logic [1:0]  hv_sync;
    logic        rd_pend;
    logic        rd_cfg;
    logic        rd_byp;
    logic        cw_dirty;
    logic [13:0] rd_const;
    logic        rvalid;
    logic [13:0] rdata;
    logic        fwr;
    logic [14:0] faddr;
    logic [13:0] fdata;
    logic        ferase;
    logic        werr;
    logic        prog_ok;
    logic        master_clear_pin_n;
    logic        cp;
    logic        xviol;
    logic [14:0] bend;
    logic        boot_region_enable_n;
    logic        storage_area_enable_n;
  } fpp_state_s;

  fpp_state_s  s_q, s_d;
  logic        mem_we;
  logic        mem_wsel;
  logic [13:0] mem_wdata;
  logic        mem_rsel;
  logic [13:0] mem_rdata;
  logic [13:0] part_w, code_w;

  // live copies of the setup words, kept beside the memory so decode is immediate
  logic [13:0] pp_q, pp_d, cw_q, cw_d;

  fpp_cfg_mem u_mem (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_en    (mem_we),
    .wr_sel   (mem_wsel),
    .wr_data  (mem_wdata),
    .rd_sel   (mem_rsel),
    .rd_data  (mem_rdata)
  );

  // decoded partition from the live word
  logic        bb_on, saf_on, wp_saf, wp_cfg, wp_boot, wp_app;
  logic [14:0] bend_c, saf_base;
  logic        in_boot, in_saf, in_cfg, is_pfm, blocked;
  logic [14:0] waddr;
  always_comb
  begin
    bb_on   = !pp_q[BOOT_REGION_ENABLE_N_BIT];
    saf_on  = !pp_q[STORAGE_AREA_ENABLE_N_BIT];
    wp_saf  = saf_on && !pp_q[WSAF_BIT];
    wp_cfg  = !pp_q[WCFG_BIT];
    wp_boot = bb_on && !pp_q[WBOOT_BIT];
    wp_app  = !pp_q[WAPP_BIT];
    // size table; wide selections clamp to half memory
    case (pp_q[BBSZ_LSB +: 3])
      3'h7:    bend_c = 15'h01ff;
      3'h6:    bend_c = 15'h03ff;
      3'h5:    bend_c = 15'h07ff;
      3'h4:    bend_c = 15'h0fff;
      default: bend_c = 15'h3fff;
    endcase
    if (bend_c > HALF_PFM_END)
      bend_c = HALF_PFM_END;
    saf_base = LAST_PFM_ADDR - SAF_SIZE + 15'h0001;
    waddr    = nv_addr[14:0];
    is_pfm   = !nv_addr[15];
    in_boot  = is_pfm && bb_on && (waddr <= bend_c);
    in_saf   = is_pfm && saf_on && (waddr >= saf_base);
    in_cfg   = (nv_addr == PART_PROT_ADDR) || (nv_addr == CODE_PROT_ADDR);
    // boot and storage off falls to the application block
    blocked  = in_cfg ? wp_cfg :
               in_boot ? wp_boot :
               in_saf ? wp_saf :
               is_pfm ? wp_app : 1'b0;
  end

  // next state of the whole block
  logic [13:0] merged;
  logic        cw_pend;
  always_comb
  begin
    s_d       = s_q;
    pp_d      = pp_q;
    cw_d      = cw_q;
    mem_we    = 1'b0;
    mem_wsel  = 1'b0;
    mem_wdata = 14'h0000;
    mem_rsel  = 1'b0;
    merged    = 14'h0000;
    // word 1 of the store keeps its pre-erase value until the port is free
    cw_pend   = s_q.cw_dirty || (s_q.st == FPP_ERASE);
    s_d.mc_sync  = {s_q.mc_sync[0], master_clear_pin};
    s_d.lvp_sync = {s_q.lvp_sync[0], lv_prog_active};
    s_d.hv_sync  = {s_q.hv_sync[0], hv_present};
    s_d.fwr      = 1'b0;
    s_d.ferase   = 1'b0;
    s_d.rvalid   = 1'b0;
    s_d.xviol    = 1'b0;
    // pin role: low-voltage enable overrides the pin enable setting
    s_d.master_clear_pin_n  = (pp_q[LVP_BIT] || master_clear_pin_enable) ? s_q.mc_sync[1] : 1'b1;
    // high-voltage entry required once low-voltage programming is off
    s_d.prog_ok = pp_q[LVP_BIT] ? 1'b1 : s_q.hv_sync[1];
    s_d.cp      = !cw_q[CP_BIT];
    s_d.bend    = bend_c;
    s_d.boot_region_enable_n    = bb_on;
    s_d.storage_area_enable_n   = saf_on;
    // storage area cannot be fetched from
    s_d.xviol   = fetch_valid && saf_on && (fetch_addr >= saf_base);
    s_d.st      = FPP_IDLE;
    // read path, answered two cycles after the request
    if (s_q.rd_pend)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = s_q.rd_cfg ? (s_q.rd_byp ? cw_q : mem_rdata) : s_q.rd_const;
    end
    s_d.rd_pend = nv_rd_req && !nv_wr_req && !bulk_erase_req;
    s_d.rd_cfg  = (nv_addr == PART_PROT_ADDR) || (nv_addr == CODE_PROT_ADDR);
    s_d.rd_byp  = cw_pend && (nv_addr == CODE_PROT_ADDR);
    mem_rsel    = (nv_addr == CODE_PROT_ADDR);
    case (nv_addr)
      PART_WORD_ADDR: s_d.rd_const = {PART_TOP_BITS, PART_CODE};
      REV_WORD_ADDR:  s_d.rd_const = {REV_TOP_BITS, MAJOR_REV, MINOR_REV};
      default:        s_d.rd_const = 14'h0000;
    endcase
    if (bulk_erase_req)
    begin
      // only path that can lift protection, or resize the boot block while it is enabled
      s_d.st     = FPP_ERASE;
      pp_d       = PART_PROT_RESET;
      cw_d       = CODE_PROT_RESET;
      mem_we     = 1'b1;
      mem_wsel   = 1'b0;
      mem_wdata  = PART_PROT_RESET;
      s_d.ferase = 1'b1;
      s_d.werr   = 1'b0;
    end
    else if (nv_wr_req && s_q.prog_ok)
    begin
      s_d.st = FPP_WRITE;
      if (blocked)
        s_d.werr = 1'b1;
      else if (nv_addr == PART_PROT_ADDR)
      begin
        // bits may only go from one to zero, except the boot size while the boot block is off; erased ones stay set only via erase
        merged = pp_q & (nv_wdata | ~PART_PROT_MASK) & PART_PROT_MASK;
        if (s_q.lvp_sync[1])
          merged[LVP_BIT] = pp_q[LVP_BIT];
        if (bb_on)
          merged[BBSZ_LSB +: 3] = pp_q[BBSZ_LSB +: 3];
        else
          merged[BBSZ_LSB +: 3] = nv_wdata[BBSZ_LSB +: 3];
        pp_d      = merged;
        mem_we    = 1'b1;
        mem_wdata = merged;
      end
      else if (nv_addr == CODE_PROT_ADDR)
      begin
        cw_d      = cw_q & (nv_wdata | ~CODE_PROT_MASK) & CODE_PROT_MASK;
        mem_we    = 1'b1;
        mem_wsel  = 1'b1;
        mem_wdata = cw_q & (nv_wdata | ~CODE_PROT_MASK) & CODE_PROT_MASK;
      end
      else if (is_pfm)
      begin
        s_d.fwr   = 1'b1;
        s_d.faddr = waddr;
        s_d.fdata = nv_wdata;
      end
      // identity and reserved words drop the write silently
    end
    // erase has port room for word 0 only, so word 1 follows on a free cycle
    s_d.cw_dirty = cw_pend && mem_we;
    if (cw_pend && !mem_we)
    begin
      mem_we    = 1'b1;
      mem_wsel  = 1'b1;
      mem_wdata = cw_q;
    end
  end

  // single register stage for all state
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // pin synchroniser starts at the idle high level so no false clear follows reset
      s_q <= '{st: FPP_IDLE, master_clear_pin_n: 1'b1, mc_sync: 2'b11, bend: HALF_PFM_END,
               rdata: 14'h0000, default: '0};
      pp_q <= PART_PROT_RESET;
      cw_q <= CODE_PROT_RESET;
    end
    else
    begin
      s_q  <= s_d;
      pp_q <= pp_d;
      cw_q <= cw_d;
    end
  end

  assign nv_rdata            = s_q.rdata;
  assign nv_rvalid           = s_q.rvalid;
  assign flash_wr_en         = s_q.fwr;
  assign flash_wr_addr       = s_q.faddr;
  assign flash_wr_data       = s_q.fdata;
  assign flash_bulk_erase    = s_q.ferase;
  assign write_error_flag    = s_q.werr;
  assign program_allowed     = s_q.prog_ok;
  assign master_clear_n      = s_q.master_clear_pin_n;
  assign code_protect_active = s_q.cp;
  assign exec_violation      = s_q.xviol;
  assign boot_end_addr       = s_q.bend;
  assign boot_enabled        = s_q.boot_region_enable_n;
  assign storage_enabled     = s_q.storage_area_enable_n;

  // protected application write never reaches the array
  a_app_guard: assert property (@(posedge core_clk) disable iff (!resetn)
    (nv_wr_req && !bulk_erase_req && s_q.prog_ok && is_pfm && !in_boot && !in_saf && wp_app)
    |=> !flash_wr_en && write_error_flag)
    else $error("application write passed protection");
  a_werr_set: assert property (@(posedge core_clk) disable iff (!resetn)
    (nv_wr_req && !bulk_erase_req && s_q.prog_ok && blocked) |=> write_error_flag)
    else $error("protected write left no error");
  a_boot_guard: assert property (@(posedge core_clk) disable iff (!resetn)
    (nv_wr_req && !bulk_erase_req && in_boot && wp_boot) |=> !flash_wr_en)
    else $error("boot write passed protection");
  a_saf_guard: assert property (@(posedge core_clk) disable iff (!resetn)
    (nv_wr_req && !bulk_erase_req && in_saf && !in_boot && wp_saf) |=> !flash_wr_en)
    else $error("storage write passed protection");
  a_cp_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
    (!cw_q[CP_BIT] && !bulk_erase_req) |=> !cw_q[CP_BIT] ##1 code_protect_active)
    else $error("code protection dropped without erase");
  a_size_lock: assert property (@(posedge core_clk) disable iff (!resetn)
    (bb_on && !bulk_erase_req) |=> $stable(pp_q[2:0]))
    else $error("boot size changed while enabled");
  a_boot_half: assert property (@(posedge core_clk) disable iff (!resetn)
    boot_end_addr <= HALF_PFM_END)
    else $error("boot block above half memory");
  a_lvp_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_q.lvp_sync[1] && pp_q[LVP_BIT] && !bulk_erase_req) |=> pp_q[LVP_BIT])
    else $error("low-voltage enable cleared during low-voltage programming");
  a_master_clear_pin_role: assert property (@(posedge core_clk) disable iff (!resetn)
    (pp_q[LVP_BIT] && $stable(pp_q[LVP_BIT])) |=> master_clear_n == $past(s_q.mc_sync[1]))
    else $error("master clear role ignored low-voltage enable");
  a_part_word: assert property (@(posedge core_clk) disable iff (!resetn)
    (nv_rd_req && !nv_wr_req && !bulk_erase_req && nv_addr == PART_WORD_ADDR)
    |=> ##1 nv_rvalid && nv_rdata[13:12] == 2'b11)
    else $error("part identity upper bits wrong");
endmodule
`default_nettype wire

// ==== pkg/fpp_pkg.sv ====
// fpp_pkg: shared constants for the flash partition protection block
// assumes a 14-bit word nonvolatile space with 15-bit word addressing plus the 8000h region
package fpp_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned WORD_W = 14;
  // configuration space addresses
  localparam logic [15:0] REV_WORD_ADDR   = 16'h8005;
  localparam logic [15:0] PART_WORD_ADDR  = 16'h8006;
  localparam logic [15:0] SETUP3_ADDR     = 16'h8009;
  localparam logic [15:0] PART_PROT_ADDR  = 16'h800a;
  localparam logic [15:0] CODE_PROT_ADDR  = 16'h800b;
  localparam logic [15:0] CFG_SPACE_BASE  = 16'h8000;
  // partition_protect_word field positions, and the code protect bit
  localparam int unsigned LVP_BIT   = 13;
  localparam int unsigned WSAF_BIT  = 11;
  localparam int unsigned WCFG_BIT  = 9;
  localparam int unsigned WBOOT_BIT = 8;
  localparam int unsigned WAPP_BIT  = 7;
  localparam int unsigned STORAGE_AREA_ENABLE_N_BIT = 4;
  localparam int unsigned BOOT_REGION_ENABLE_N_BIT  = 3;
  localparam int unsigned BBSZ_LSB  = 0;
  localparam int unsigned CP_BIT    = 0;
  // mask of defined bits and erased values
  localparam logic [13:0] PART_PROT_MASK  = 14'h2b9f;
  localparam logic [13:0] PART_PROT_RESET = 14'h2b9f;
  localparam logic [13:0] CODE_PROT_MASK  = 14'h0001;
  localparam logic [13:0] CODE_PROT_RESET = 14'h0001;
  // flash geometry: 16k words, storage area is last 128 words
  localparam logic [14:0] LAST_PFM_ADDR = 15'h3fff;
  localparam logic [14:0] HALF_PFM_END  = 15'h1fff;
  localparam logic [14:0] SAF_SIZE      = 15'h0080;
  // identity words, fixed upper bits
  localparam logic [1:0] PART_TOP_BITS = 2'h3;
  localparam logic [1:0] REV_TOP_BITS  = 2'h2;
  // nonvolatile write response states
  typedef enum logic [1:0] {
    FPP_IDLE  = 2'b00,
    FPP_WRITE = 2'b01,
    FPP_ERASE = 2'b10
  } fpp_state_e;
endpackage
